//--- pkg/link_cmd_pkg.sv
// constants and types shared by the link command processor block
package link_cmd_pkg;

  // ****************************************
  // register map (byte addresses, apb words)
  // ****************************************
  localparam logic [7:0] OFF_COMMAND_WORD = 8'h00;
  localparam logic [7:0] OFF_RESULT_BYTE = 8'h04;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ****************************************
  // command word field positions
  // ****************************************
  localparam int BIT_IGNORE = 31;
  localparam int BIT_WRITE = 15;
  localparam int BIT_PROG = 14;
  localparam int BIT_REQUEST = 13;
  localparam int BIT_TRANSFER = 12;
  localparam int BIT_STARTSTOP = 11;
  localparam int TYPE_HI = 10;
  localparam int TYPE_LO = 8;
  localparam int ADDR_HI = 10;

  // start/stop type codes and the global halt value
  localparam logic [2:0] TYPE_STOP = 3'h0;
  localparam logic [2:0] TYPE_START_NORMAL = 3'h1;
  localparam logic [2:0] TYPE_START_SETUP = 3'h7;
  localparam logic [15:0] GLOBAL_HALT_COMMAND = 16'h0800;

  // ****************************************
  // local read-only parameter addresses
  // ****************************************
  localparam logic [10:0] PAR_IF_TYPE = 11'h000;
  localparam logic [10:0] PAR_PORT_WIDTH = 11'h001;
  localparam logic [10:0] PAR_REV_HIGH = 11'h002;
  localparam logic [10:0] PAR_REV_LOW = 11'h003;
  localparam logic [10:0] PAR_GEN_IN = 11'h004;
  localparam logic [10:0] PAR_GEN_OUT = 11'h005;
  localparam logic [10:0] PAR_PROC_TYPE = 11'h006;
  localparam logic [10:0] PAR_CHANNELS = 11'h007;
  localparam logic [7:0] PORT_WIDTH_VALUE = 8'h08;
  localparam logic [7:0] GENERAL_IO_COUNT = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int LINK_TIMEOUT_US = 100;
  // longest wait for the link engine, in clock cycles
  localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * CLK_MHZ;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    op_probe_normal,
    op_probe_setup,
    op_transfer
  } link_op_t;

  typedef enum logic {
    st_idle,
    st_wait_link
  } fsm_t;

endpackage : link_cmd_pkg

//--- design/link_command_processor.sv
// apb command/result register pair of the serial link command processor
//
// Operation
// [RULE1] command word is 16 bits, right justified
// [RULE2] bits 15/13/12/11 select write/request/transfer/startstop
// [RULE3] bit 14 resets processor, enables program load
// [RULE4] type 000 stop, 001 normal, 111 setup start
// [RULE5] low byte selects channels for the operation
// [RULE6] write launches; clearing to zero signals completion
// [RULE7] host writes only when idle, except halt/ignore
// [RULE8] writes with bit 31 set are discarded
// [RULE9] eight bit result register, right justified
// [RULE10] local read: request, poll zero, read result
// [RULE11] local write: poll, write byte, then command
// [RULE12] fixed read-only local parameters at 0..7
// [RULE13] stop or reset initialises all channel state
// [RULE14] start probes selected channels for remote devices
// [RULE15] normal start leaves channel chattering zero outputs
// [RULE16] start result: one marks channel failed start
// [RULE17] host repeats transfers within remote watchdog time
// [RULE18] global halt stops all, resets channel variables
// [RULE19] discovery only when starting a stopped interface
// [RULE20] masked stop keeps other channel variables intact
// [RULE21] transfer runs masked channels, completes or times out
// [RULE22] host masks only channels that started
// [RULE23] transfer result: set bit flags failed channel
// [RULE24] local fault bits sticky until a stop
// [RULE25] write to read-only parameter completes, no change
//
// Implementation choices: the register offsets and register access over APB.
module link_command_processor
  import link_cmd_pkg::*;
#(
  parameter int NUM_CHAN = 8,
  parameter int TIMEOUT_CYC = LINK_TIMEOUT_CYC,
  parameter logic [7:0] IF_TYPE_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PROC_TYPE_CODE = 8'ha5, // arbitrary value
  parameter logic [7:0] REV_HIGH = 8'h01,
  parameter logic [7:0] REV_LOW = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic link_req,
  output link_op_t link_op,
  output logic [7:0] link_mask,
  input wire logic link_done,
  input wire logic [7:0] link_fail,
  output logic [7:0] chan_active,
  output logic [7:0] chan_setup,
  output logic [7:0] chan_chatter,
  output logic [7:0] chan_fault,
  output logic prog_load
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (NUM_CHAN < 1 || NUM_CHAN > 8) begin : g_chk_chan
    $error("NUM_CHAN must be 1 to 8");
  end
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_chk_tmo
    $error("TIMEOUT_CYC must fit 16 bits");
  end

  // channels that exist in this build
  localparam logic [8:0] CHAN_ONE = 9'h001;
  localparam logic [7:0] CHAN_VALID =
    8'((CHAN_ONE << NUM_CHAN) - CHAN_ONE);
  localparam logic [15:0] TMO_LOAD = 16'(TIMEOUT_CYC);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] cmd;    // pending command, zero when idle
    logic [7:0] data;    // result / parameter byte
    logic [7:0] active;  // channels running
    logic [7:0] setup;   // channels started in setup mode
    logic [7:0] chatter; // channels sending zero outputs
    logic [7:0] fault;   // sticky local fault per channel
    logic prog;          // processor held for program load
    logic req;           // link engine request
    link_op_t op;        // operation handed to the link
    logic [7:0] mask;    // channels handed to the link
    logic [15:0] cnt;    // link timeout down counter
    fsm_t fsm;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t st;
  state_t next_st;

  // ****************************************
  // helpers
  // ****************************************
  // clear every channel variable; used by halt and reset bit
  function automatic state_t init_channels(input state_t s);
    state_t r;
    r = s;
    r.cmd = COMMAND_RESET;
    r.data = RESULT_RESET;
    r.active = 8'h00;
    r.setup = 8'h00;
    r.chatter = 8'h00;
    r.fault = 8'h00;
    r.req = 1'b0;
    r.mask = 8'h00;
    r.cnt = 16'h0000;
    r.fsm = st_idle;
    return r;
  endfunction : init_channels

  // read-only local parameter table
  function automatic logic [7:0] param_byte(input logic [10:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      PAR_IF_TYPE: v = IF_TYPE_CODE;
      PAR_PORT_WIDTH: v = PORT_WIDTH_VALUE;
      PAR_REV_HIGH: v = REV_HIGH;
      PAR_REV_LOW: v = REV_LOW;
      PAR_GEN_IN: v = GENERAL_IO_COUNT;
      PAR_GEN_OUT: v = GENERAL_IO_COUNT;
      PAR_PROC_TYPE: v = PROC_TYPE_CODE;
      PAR_CHANNELS: v = 8'(NUM_CHAN);
      default: v = 8'h00;
    endcase
    return v;
  endfunction : param_byte

  // ****************************************
  // bus decode
  // ****************************************
  logic apb_setup;
  logic apb_wr;
  logic wr_cmd;
  logic wr_data;
  logic is_halt;
  logic cmd_ok;
  logic [15:0] c;
  logic [7:0] cm;

  // zero wait state: pready rises in the first access cycle
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && st.pready && pwrite;
  assign wr_cmd = apb_wr && (paddr == OFF_COMMAND_WORD);
  assign wr_data = apb_wr && (paddr == OFF_RESULT_BYTE);
  assign c = pwdata[15:0];
  assign cm = c[7:0] & CHAN_VALID;
  assign is_halt = (c == GLOBAL_HALT_COMMAND);
  // busy writes are dropped unless they are the halt
  assign cmd_ok = wr_cmd && !pwdata[BIT_IGNORE] && // RULE8
                  (st.cmd == COMMAND_RESET || is_halt); // RULE7

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] fail;
    fail = 8'h00;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // register read data captured in the setup cycle
    if (apb_setup) begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      unique case (paddr)
        OFF_COMMAND_WORD: begin
          next_st.prdata = {16'h0000, st.cmd}; // RULE1 RULE6
        end
        OFF_RESULT_BYTE: begin
          next_st.prdata = {24'h0000_00, st.data}; // RULE9
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end

    // link engine wait; a dead link counts as all failed
    if (st.fsm == st_wait_link) begin
      if (link_done || st.cnt == 16'h0001) begin
        fail = link_done ? (link_fail & st.mask) : st.mask; // RULE21
        next_st.req = 1'b0;
        next_st.fsm = st_idle;
        next_st.cmd = COMMAND_RESET; // RULE6
        if (st.op == op_transfer) begin
          next_st.data = fail; // RULE23
          next_st.fault = st.fault | fail; // RULE24
          next_st.chatter = st.chatter & ~st.mask; // RULE15
        end else begin
          // data already holds channels refused at launch
          next_st.data = st.data | fail; // RULE16
          next_st.active = st.active | (st.mask & ~fail); // RULE14
          if (st.op == op_probe_setup) begin
            next_st.setup = st.mask & ~fail;
          end else begin
            next_st.chatter = st.mask & ~fail; // RULE15
          end
        end
      end else begin
        next_st.cnt = st.cnt - 16'h0001;
      end
    end

    // host byte for a following local write
    if (wr_data) begin
      next_st.data = pwdata[7:0]; // RULE11
    end

    // command launch; the halt wins over a running command
    if (cmd_ok) begin
      if (is_halt) begin
        next_st = init_channels(next_st); // RULE18 RULE13
      end else if (c[BIT_PROG]) begin
        next_st = init_channels(next_st); // RULE3 RULE13
        next_st.prog = 1'b1; // RULE3
      end else begin
        next_st.prog = 1'b0;
        if (c[BIT_REQUEST]) begin // RULE2
          // local access completes at once
          if (!c[BIT_WRITE]) begin
            next_st.data = param_byte(c[ADDR_HI:0]); // RULE10 RULE12
          end
          // every parameter is read-only, so a write only completes
          next_st.cmd = COMMAND_RESET; // RULE25
        end else if (c[BIT_TRANSFER]) begin
          next_st.data = 8'h00;
          if (cm != 8'h00) begin
            next_st.cmd = c; // RULE6
            next_st.req = 1'b1; // RULE21
            next_st.op = op_transfer;
            next_st.mask = cm; // RULE5
            next_st.cnt = TMO_LOAD;
            next_st.fsm = st_wait_link;
          end
        end else if (c[BIT_STARTSTOP]) begin
          unique case (c[TYPE_HI:TYPE_LO]) // RULE4
            TYPE_STOP: begin
              // masked stop leaves faults and other channels alone
              next_st.active = st.active & ~c[7:0]; // RULE20
              next_st.setup = st.setup & ~c[7:0]; // RULE20
              next_st.chatter = st.chatter & ~c[7:0]; // RULE20
            end
            TYPE_START_NORMAL, TYPE_START_SETUP: begin
              // missing channels fail straight away
              next_st.data = c[7:0] & ~CHAN_VALID; // RULE16
              if (st.active != 8'h00) begin
                // already running: no rediscovery
                next_st.data = c[7:0] & ~st.active; // RULE19
              end else if (cm != 8'h00) begin
                next_st.cmd = c;
                next_st.req = 1'b1; // RULE14
                next_st.op = (c[TYPE_HI:TYPE_LO] == TYPE_START_SETUP)
                           ? op_probe_setup : op_probe_normal;
                next_st.mask = cm; // RULE5
                next_st.cnt = TMO_LOAD;
                next_st.fsm = st_wait_link;
              end
            end
            default: begin
              // unknown type: completes, with prog_load cleared as its only effect
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs, all straight from the state register
  // ****************************************
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign link_req = st.req;
  assign link_op = st.op;
  assign link_mask = st.mask;
  assign chan_active = st.active;
  assign chan_setup = st.setup;
  assign chan_chatter = st.chatter;
  assign chan_fault = st.fault;
  assign prog_load = st.prog;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic acc_ok;
  assign acc_ok = cmd_ok && !is_halt && !c[BIT_PROG];

  a_ignore_write: assert property ( // RULE8
    wr_cmd && pwdata[BIT_IGNORE] && st.fsm == st_idle
    |=> st.cmd == COMMAND_RESET && chan_active == $past(chan_active) &&
        prog_load == $past(prog_load)
  ) else $error("ignored command changed state");

  a_read_pending: assert property ( // RULE6
    apb_setup && !pwrite && paddr == OFF_COMMAND_WORD
    ##1 penable |-> prdata == {16'h0000, $past(st.cmd)}
  ) else $error("command read wrong");

  a_halt_clears: assert property ( // RULE18
    cmd_ok && is_halt
    |=> chan_active == 8'h00 && chan_fault == 8'h00 && !link_req
  ) else $error("halt left channel state");

  a_mask_stop: assert property ( // RULE20
    acc_ok && !c[BIT_REQUEST] && !c[BIT_TRANSFER] &&
    c[BIT_STARTSTOP] && c[TYPE_HI:TYPE_LO] == TYPE_STOP
    |=> (chan_active & $past(pwdata[7:0])) == 8'h00 &&
        chan_fault == $past(st.fault)
  ) else $error("masked stop wrong");

  a_local_read: assert property ( // RULE12
    acc_ok && c[BIT_REQUEST] && !c[BIT_WRITE] &&
    c[ADDR_HI:0] == PAR_PORT_WIDTH
    |=> st.data == PORT_WIDTH_VALUE && st.cmd == COMMAND_RESET
  ) else $error("port width parameter wrong");

  a_ro_write: assert property ( // RULE25
    acc_ok && c[BIT_REQUEST] && c[BIT_WRITE]
    |=> st.data == $past(st.data) && st.cmd == COMMAND_RESET
  ) else $error("read-only write changed data");

  a_req_busy: assert property ( // RULE21
    link_req |-> st.cmd != COMMAND_RESET && link_mask != 8'h00
  ) else $error("link request while idle");

  a_timeout_end: assert property ( // RULE21
    link_req && !link_done && st.cnt == 16'h0001 && !cmd_ok && !wr_data
    |=> !link_req && st.cmd == COMMAND_RESET &&
        st.data == (($past(link_op) == op_transfer) ? $past(st.mask)
                   : ($past(st.data) | $past(st.mask)))
  ) else $error("timeout did not fail all");

  a_xfer_result: assert property ( // RULE23
    link_req && link_done && link_op == op_transfer && !cmd_ok && !wr_data
    |=> st.data == $past(link_fail & link_mask) &&
        st.cmd == COMMAND_RESET
  ) else $error("transfer result wrong");

  a_fault_sticky: assert property ( // RULE24
    !(cmd_ok && (is_halt || c[BIT_PROG]))
    |=> (chan_fault & $past(chan_fault)) == $past(chan_fault)
  ) else $error("fault bit dropped");

  a_prog_reset: assert property ( // RULE3
    cmd_ok && !is_halt && c[BIT_PROG]
    |=> prog_load && chan_active == 8'h00
  ) else $error("reset bit ignored");

  c_start_ok: cover property (
    link_req && link_op == op_probe_normal && link_done ##1
    chan_active != 8'h00);
  c_xfer_fail: cover property (
    link_req && link_op == op_transfer && link_done &&
    (link_fail & link_mask) != 8'h00);
  c_timeout: cover property (link_req && st.cnt == 16'h0001);
  c_halt_busy: cover property (link_req && cmd_ok && is_halt);

endmodule : link_command_processor

//--- verif/link_engine_model.sv
// behavioural model of the serial link engine and its remote devices
module link_engine_model
  import link_cmd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_req,
  input wire link_op_t link_op,
  input wire logic [7:0] link_mask,
  input wire logic [7:0] resp_delay,
  input wire logic [7:0] fail_pat,
  output logic link_done,
  output logic [7:0] link_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // answer timing
  // ****************************************
  logic [7:0] cnt; // cycles spent on the current run
  logic [7:0] last; // failure mask of the last answer
  // probe or transfer ends after resp_delay cycles; a delay never
  // reached stands for remote devices that never answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      link_done <= 1'b0;
      last <= 8'h00;
    end else begin
      link_done <= 1'b0;
      if (link_req && !link_done && cnt == resp_delay) begin
        link_done <= 1'b1;
        last <= fail_pat & link_mask;
        cnt <= 8'h00;
      end else if (link_req && !link_done) begin
        cnt <= cnt + 8'h01;
      end else begin
        cnt <= 8'h00;
      end
    end
  end
  // outside the answer cycle the mask is not held, so show its inverse
  assign link_fail = link_done ? last : ~last;
endmodule : link_engine_model

//--- verif/testbench.sv
// self-checking bench for the link command processor
module testbench;
  import link_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bench signals
  // ****************************************
  localparam logic [7:0] IF_CODE = 8'h3c; // arbitrary value
  localparam logic [7:0] PROC_CODE = 8'hc3; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, link_mask, link_fail, resp_delay, fail_pat;
  logic [31:0] pwdata, prdata, r;
  logic link_req, link_done, prog_load, e;
  link_op_t link_op;
  logic [7:0] chan_active, chan_setup, chan_chatter, chan_fault;
  int bad_count, checked, cycles;
  typedef struct {logic [10:0] a; logic [7:0] v;} row_t;
  row_t rows[8] = '{'{PAR_IF_TYPE, IF_CODE}, '{PAR_PORT_WIDTH, 8'h08},
    '{PAR_REV_HIGH, 8'h02}, '{PAR_REV_LOW, 8'h07}, '{PAR_GEN_IN, 8'h00},
    '{PAR_GEN_OUT, 8'h00}, '{PAR_PROC_TYPE, PROC_CODE},
    '{PAR_CHANNELS, 8'h04}};
  link_command_processor #(.NUM_CHAN(4), .TIMEOUT_CYC(20),
    .IF_TYPE_CODE(IF_CODE), .PROC_TYPE_CODE(PROC_CODE),
    .REV_HIGH(8'h02), .REV_LOW(8'h07)) link_command_processor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_req(link_req),
    .link_op(link_op), .link_mask(link_mask), .link_done(link_done),
    .link_fail(link_fail), .chan_active(chan_active),
    .chan_setup(chan_setup), .chan_chatter(chan_chatter),
    .chan_fault(chan_fault), .prog_load(prog_load));
  link_engine_model link_engine_model_inst (.pclk(pclk),
    .presetn(presetn), .link_req(link_req), .link_op(link_op),
    .link_mask(link_mask), .resp_delay(resp_delay), .fail_pat(fail_pat),
    .link_done(link_done), .link_fail(link_fail));
  // ****************************************
  // tasks
  // ****************************************
  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // write a command, poll until cleared, then fetch the result byte
  task automatic run(input logic [31:0] c);
    apb(1'b1, OFF_COMMAND_WORD, c);
    repeat (60) begin
      apb(1'b0, OFF_COMMAND_WORD, 32'h0000_0000);
      if (r === 32'h0000_0000) break;
    end
    chk(r, 32'h0000_0000);
    apb(1'b0, OFF_RESULT_BYTE, 32'h0000_0000);
  endtask : run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // the whole run needs a few hundred cycles; far more means a hang
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    resp_delay = 8'h00;
    fail_pat = 8'h00;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_COMMAND_WORD, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk({16'h0, chan_active, chan_fault}, 32'h0000_0000);
    $display("reset test done");
    // table of read-only local parameters
    foreach (rows[i]) begin
      run(32'h0000_2000 | 32'(rows[i].a));
      chk(r, {24'h0, rows[i].v});
    end
    $display("parameter table test done");
    // write to a read-only parameter changes nothing
    apb(1'b1, OFF_RESULT_BYTE, 32'h0000_005c);
    run(32'h0000_a007);
    chk(r, 32'h0000_005c);
    run(32'h0000_2007);
    chk(r, 32'h0000_0004);
    // result register holds only its low byte
    apb(1'b1, OFF_RESULT_BYTE, 32'hffff_ffa5);
    apb(1'b0, OFF_RESULT_BYTE, 32'h0000_0000);
    chk(r, 32'h0000_00a5);
    apb(1'b1, 8'h08, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("register test done");
    // normal start, slow answer; busy read shows the pending command
    resp_delay <= 8'h0a;
    fail_pat <= 8'h02;
    apb(1'b1, OFF_COMMAND_WORD, 32'h0000_090f);
    apb(1'b0, OFF_COMMAND_WORD, 32'h0000_0000);
    chk(r, 32'h0000_090f);
    chk({21'h0, link_req, link_op, link_mask}, 32'h0000_040f);
    run(32'h8000_0000);
    chk(r, 32'h0000_0002);
    chk({16'h0, chan_active, chan_chatter}, 32'h0000_0d0d);
    // transfer on two channels, one fails
    resp_delay <= 8'h00;
    fail_pat <= 8'h04;
    run(32'h0000_1005);
    chk(r, 32'h0000_0004);
    chk({16'h0, chan_fault, chan_chatter}, 32'h0000_0408);
    // next transfer soon after, clean: zero result, fault still held
    fail_pat <= 8'h00;
    run(32'h0000_1001);
    chk(r, 32'h0000_0000);
    chk({24'h0, chan_fault}, 32'h0000_0004);
    // start to a running interface does no discovery
    run(32'h0000_0902);
    chk(r, 32'h0000_0002);
    // ignored write leaves everything as it was
    apb(1'b1, OFF_COMMAND_WORD, 32'h8000_0800);
    chk({24'h0, chan_active}, 32'h0000_000d);
    // masked stop keeps faults
    run(32'h0000_0801);
    chk({16'h0, chan_active, chan_fault}, 32'h0000_0c04);
    run(32'h0000_0800);
    chk({16'h0, chan_active, chan_fault}, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    $display("start and transfer test done");
    // setup start, channels beyond the configured count fail
    fail_pat <= 8'h00;
    run(32'h0000_0f33);
    chk(r, 32'h0000_0030);
    chk({16'h0, chan_active, chan_setup}, 32'h0000_0303);
    // silent remote devices: run ends by timeout, all masked failed
    run(32'h0000_0800);
    resp_delay <= 8'hff;
    run(32'h0000_0901);
    chk(r, 32'h0000_0001);
    $display("setup and timeout test done");
    // processor reset bit, then cleared by an ordinary command
    run(32'h0000_4000);
    chk({31'h0, prog_load}, 32'h0000_0001);
    run(32'h0000_2001);
    chk({31'h0, prog_load}, 32'h0000_0000);
    $display("program load test done");
    // reset in mid-run drops the pending command and the link request
    apb(1'b1, OFF_COMMAND_WORD, 32'h0000_0901);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({22'h0, link_req, prog_load, chan_active}, 32'h0000_0000);
    apb(1'b0, OFF_COMMAND_WORD, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : testbench
